// file: enc_counter.sv
// Purpose: Quadrature counting electronics with APB register access.
// Assumes: Link inputs are synchronous to pclk; channels and reference resynchronised anyway.
// Notes: Status bits set by events, cleared by writing ones.
//
// Summary of operation
// - Head splits signal period into equal steps
// - Interpolation factor fixed per build
// - Two channels a quarter period apart
// - One count per edge of either channel
// - Counter catches edges at least spacing
// - Edge spacing allows driver, cable, receiver skew
// - Reference pulse one increment wide
// - Reference pulse loads preset into position
// - Head flags faulty scanning signals
// - Test input routes raw signals out
// - Two switch outputs; second held low in selectable variant
// - Selectable variant: track qualifies reference
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module enc_counter
  import enc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  enc_link_if.counter link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import enc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for channels and reference
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      sync1_reg <= {link.reference_pulse_out, link.quadrature_out_first,
        link.quadrature_out_second};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire a_now = sync2_reg[1];
  wire b_now = sync2_reg[0];
  wire a_chg = a_now ^ prev_reg[1];
  wire b_chg = b_now ^ prev_reg[0];
  wire one_edge = a_chg ^ b_chg;
  wire both_edge = a_chg & b_chg;
  // First channel leads: A changed to differ from B, or B to match A
  wire count_up = (a_chg & (a_now != b_now)) |
    (b_chg & (a_now == b_now));
  wire ref_rise = sync2_reg[2] & ~prev_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // Edge spacing watch
  logic [15:0] gap_reg;
  wire gap_short = one_edge && (gap_reg < 16'(EDGE_EFF_CYC));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_reg <= 16'hffff;
    else if (one_edge | both_edge) gap_reg <= 16'h0001;
    else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] preset_reg;
  logic [1:0] ctrl_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic test_reg;
  wire count_en = ctrl_reg[0];
  wire ref_en = ctrl_reg[1];
  wire wr = psel & penable & pwrite;
  wire wr_ctrl = wr && (paddr == ADDR_CTRL);
  wire wr_status = wr && (paddr == ADDR_STATUS);
  wire wr_mask = wr && (paddr == ADDR_MASK);
  wire wr_preset = wr && (paddr == ADDR_PRESET);
  wire [3:0] events;
  assign events[IRQ_REF] = ref_rise & ref_en;
  assign events[IRQ_MISS] = both_edge;
  assign events[IRQ_FAULT] = link.fault_flag;
  assign events[IRQ_SPACE] = gap_short;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= POS_RESET;
    end else if (events[IRQ_REF]) begin
      pos_reg <= preset_reg;
    end else if (count_en & one_edge) begin
      pos_reg <= count_up ? pos_reg + 1'b1 : pos_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_reg <= PRESET_RESET;
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
      status_reg <= 4'h0;
      test_reg <= 1'b0;
    end else begin
      if (wr_preset) preset_reg <= pwdata;
      if (wr_ctrl) ctrl_reg <= pwdata[1:0];
      if (wr_ctrl) test_reg <= pwdata[2];
      if (wr_mask) mask_reg <= pwdata[3:0];
      // Set wins over write-one clear
      status_reg <= (status_reg & ~(wr_status ? pwdata[3:0] : 4'h0))
        | events;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read path, zero wait states
  wire [31:0] levels = {27'h0, link.switch_output_second,
    link.switch_output_first, link.fault_flag, a_now, b_now};
  wire mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) |
    (paddr == ADDR_MASK) | (paddr == ADDR_POS) |
    (paddr == ADDR_PRESET) | (paddr == ADDR_LEVELS);
  wire [31:0] rd_mux =
    (paddr == ADDR_CTRL) ? {29'h0, test_reg, ctrl_reg} :
    (paddr == ADDR_STATUS) ? {28'h0, status_reg} :
    (paddr == ADDR_MASK) ? {28'h0, mask_reg} :
    (paddr == ADDR_POS) ? pos_reg :
    (paddr == ADDR_PRESET) ? preset_reg :
    (paddr == ADDR_LEVELS) ? levels : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite) prdata <= rd_mux;
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(status_reg & mask_reg);
  // Set-up mode: head shows raw signals while this bit is high
  assign link.test_in = test_reg;
endmodule : enc_counter
`default_nettype wire

// file: enc_pkg.sv
// Purpose: Shared constants for the encoder output head and its counter.
// Assumes: One clock pclk at 40 MHz.
// Notes: Edge skew budget sets the least edge spacing the counter checks.
package enc_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned PHASE_W = 8;
  localparam int unsigned POS_W = 32;
  localparam int unsigned INTERP_FACTOR = 10;
  localparam int unsigned DRIVER_SKEW_NS = 10;
  localparam int unsigned RECEIVER_SKEW_NS = 10;
  localparam int unsigned CABLE_SKEW_PS_PER_M = 200;
  localparam int unsigned CABLE_M = 3;
  localparam int unsigned EDGE_MIN_NS = 300;
  localparam int unsigned EDGE_EFF_NS = EDGE_MIN_NS - DRIVER_SKEW_NS
    - RECEIVER_SKEW_NS - (CABLE_SKEW_PS_PER_M * CABLE_M) / 1000;
  localparam int unsigned EDGE_EFF_CYC_RAW = (EDGE_EFF_NS * CLK_MHZ) / 1000;
  localparam int unsigned EDGE_EFF_CYC =
    (EDGE_EFF_CYC_RAW < 1) ? 1 : EDGE_EFF_CYC_RAW;
  localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
  localparam logic [POS_W-1:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0c;
  localparam logic [7:0] ADDR_PRESET = 8'h10;
  localparam logic [7:0] ADDR_LEVELS = 8'h14;
  localparam int unsigned IRQ_REF = 0;
  localparam int unsigned IRQ_MISS = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_SPACE = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  function automatic logic [1:0] gray2(input logic [1:0] s);
    gray2 = {s[1], s[1] ^ s[0]};
  endfunction : gray2
endpackage : enc_pkg

// file: enc_link_if.sv
// Purpose: Square-wave encoder link between head and counter.
// Assumes: Differential pairs modelled as true and complement signals.
// Notes: No clocking block; both ends share pclk.
`timescale 1ns/10ps
`default_nettype none
interface enc_link_if;
  logic quadrature_out_first;
  logic quadrature_out_first_n;
  logic quadrature_out_second;
  logic quadrature_out_second_n;
  logic reference_pulse_out;
  logic reference_pulse_out_n;
  logic fault_flag;
  logic switch_output_first;
  logic switch_output_second;
  logic test_in;
  modport head (
    output quadrature_out_first, quadrature_out_first_n,
    output quadrature_out_second, quadrature_out_second_n,
    output reference_pulse_out, reference_pulse_out_n,
    output fault_flag, switch_output_first, switch_output_second,
    input test_in
  );
  modport counter (
    input quadrature_out_first, quadrature_out_first_n,
    input quadrature_out_second, quadrature_out_second_n,
    input reference_pulse_out, reference_pulse_out_n,
    input fault_flag, switch_output_first, switch_output_second,
    output test_in
  );
endinterface : enc_link_if
`default_nettype wire

// file: enc_head_interp.sv
// Purpose: Interpolating scanning head output stage.
// Assumes: Phase steps arrive as one-cycle pulses; at most one per cycle.
// Notes: Reference pulse spans exactly one quadrature state.
`timescale 1ns/10ps
`default_nettype none
module enc_head_interp
  import enc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  enc_link_if.head link,
  input wire logic step_fwd,
  input wire logic step_rev,
  input wire logic [PHASE_W-1:0] ref_phase,
  input wire logic ref_mark_seen,
  input wire logic ref_select_track,
  input wire logic selectable_ref,
  input wire logic switch_track_first,
  input wire logic switch_track_second,
  input wire logic signal_fault,
  input wire logic raw_test_first,
  input wire logic raw_test_second
);
  import enc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Subdivision counter within one signal period
  localparam logic [PHASE_W-1:0] SUBDIV = PHASE_W'(INTERP_FACTOR * 4 - 1);

  logic [PHASE_W-1:0] phase_reg;
  logic [PHASE_W-1:0] phase_next;
  logic [1:0] quad_reg;
  logic ref_reg;
  logic fault_reg;
  logic sw1_reg;
  logic sw2_reg;
  wire fwd = step_fwd & ~step_rev;
  wire rev = step_rev & ~step_fwd;
  wire at_top = (phase_reg == SUBDIV);
  wire at_zero = (phase_reg == '0);
  wire ref_qualified = ref_mark_seen & (~selectable_ref | ref_select_track);
  // Compare the next phase so the pulse lines up with its quadrature state
  wire ref_hit = ref_qualified && (phase_next == ref_phase);

  // Equal subdivisions; one edge per boundary
  assign phase_next = fwd ? (at_top ? '0 : phase_reg + 1'b1) :
    rev ? (at_zero ? SUBDIV : phase_reg - 1'b1) : phase_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= '0;
      quad_reg <= 2'h0;
      ref_reg <= 1'b0;
      fault_reg <= 1'b0;
      sw1_reg <= 1'b0;
      sw2_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      quad_reg <= gray2(phase_next[1:0]);
      ref_reg <= ref_hit;
      fault_reg <= signal_fault;
      sw1_reg <= switch_track_first;
      sw2_reg <= selectable_ref ? 1'b0 : switch_track_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output mux; test input substitutes raw signals
  // First channel leads while stepping forward
  wire q1 = link.test_in ? raw_test_first : quad_reg[0];
  wire q2 = link.test_in ? raw_test_second : quad_reg[1];
  assign link.quadrature_out_first = q1;
  assign link.quadrature_out_first_n = ~q1;
  assign link.quadrature_out_second = q2;
  assign link.quadrature_out_second_n = ~q2;
  assign link.reference_pulse_out = ref_reg & ~link.test_in;
  assign link.reference_pulse_out_n = ~(ref_reg & ~link.test_in);
  assign link.fault_flag = fault_reg;
  assign link.switch_output_first = sw1_reg;
  assign link.switch_output_second = sw2_reg;
endmodule : enc_head_interp
`default_nettype wire

// file: enc_link_checker.sv
// Purpose: Assertions on the link between head and counter.
// Assumes: Both ends run on pclk.
// Notes: Watches link signals only.
`timescale 1ns/10ps
`default_nettype none
module enc_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic quadrature_out_first,
  input wire logic quadrature_out_first_n,
  input wire logic quadrature_out_second,
  input wire logic quadrature_out_second_n,
  input wire logic reference_pulse_out,
  input wire logic reference_pulse_out_n,
  input wire logic fault_flag,
  input wire logic switch_output_first,
  input wire logic switch_output_second,
  input wire logic test_in
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic [1:0] quad = {quadrature_out_first, quadrature_out_second};
  wire logic any_out = fault_flag | switch_output_first | switch_output_second;
  //////////////////////////////////////////////////////////////////////////
  property p_pair_a; quadrature_out_first_n != quadrature_out_first;
  endproperty
  a_pair_a: assert property (p_pair_a) else $error("pair a equal");
  property p_pair_b; quadrature_out_second_n != quadrature_out_second;
  endproperty
  a_pair_b: assert property (p_pair_b) else $error("pair b equal");
  property p_pair_r; reference_pulse_out_n != reference_pulse_out;
  endproperty
  a_pair_r: assert property (p_pair_r) else $error("ref pair equal");
  property p_one_edge;
    !test_in && !$past(test_in) && $changed(quad) |->
      $countones(quad ^ $past(quad)) == 1;
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("double edge");
  property p_ref_state;
    reference_pulse_out && $past(reference_pulse_out) |-> $stable(quad);
  endproperty
  a_ref_state: assert property (p_ref_state) else $error("ref too wide");
  property p_reset_idle;
    $rose(presetn) |-> quad == 2'b00 && !reference_pulse_out && !any_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy at reset");
  property p_test_ref; test_in |-> !reference_pulse_out;
  endproperty
  a_test_ref: assert property (p_test_ref) else $error("test ref");
  c_ref: cover property ($rose(reference_pulse_out));
  c_test: cover property ($rose(test_in));
  c_fault: cover property ($rose(fault_flag));
  c_sw: cover property ($rose(switch_output_second));
endmodule : enc_link_checker
`default_nettype wire

// file: incremental_quadrature_encoder_output_tb.sv
// Purpose: Bench for head and counter joined by the link.
// Assumes: Counter drives the test input from its control register.
// Notes: Rows step the head, then read position and levels.
`timescale 1ns/10ps
`default_nettype none
module incremental_quadrature_encoder_output_tb;
  import enc_pkg::*;
  typedef struct {int n; logic [1:0] d; logic [3:0] pin;
    logic [31:0] pos; logic [2:0] lv;} row_s;
  // Pins are sel, fault, switch two, switch one
  row_s rows [5] = '{'{5, 2'b01, 4'h0, 32'h0000_0005, 3'h0},
    '{3, 2'b10, 4'h1, 32'h0000_0002, 3'h2}, '{2, 2'b11, 4'h2, 32'h0000_0002, 3'h4},
    '{4, 2'b10, 4'hb, 32'hffff_fffe, 3'h2}, '{1, 2'b01, 4'h4, 32'hffff_ffff, 3'h1}};
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, err;
  logic step_fwd, step_rev, ref_mark_seen, ref_select_track, selectable_ref;
  logic switch_track_first, switch_track_second, signal_fault;
  logic raw_test_first, raw_test_second;
  logic [7:0] paddr, ref_phase;
  logic [31:0] pwdata, prdata, q;
  int fail_count, checks_done;
  enc_link_if link ();
  enc_head_interp u_enc_head_interp (.pclk(pclk), .presetn(presetn),
    .link(link), .step_fwd(step_fwd), .step_rev(step_rev),
    .ref_phase(ref_phase), .ref_mark_seen(ref_mark_seen),
    .ref_select_track(ref_select_track), .selectable_ref(selectable_ref),
    .switch_track_first(switch_track_first),
    .switch_track_second(switch_track_second), .signal_fault(signal_fault),
    .raw_test_first(raw_test_first), .raw_test_second(raw_test_second));
  enc_counter u_enc_counter (.pclk(pclk), .presetn(presetn), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  enc_link_checker u_enc_link_checker (.pclk(pclk), .presetn(presetn),
    .quadrature_out_first(link.quadrature_out_first),
    .quadrature_out_first_n(link.quadrature_out_first_n),
    .quadrature_out_second(link.quadrature_out_second),
    .quadrature_out_second_n(link.quadrature_out_second_n),
    .reference_pulse_out(link.reference_pulse_out),
    .reference_pulse_out_n(link.reference_pulse_out_n),
    .fault_flag(link.fault_flag), .switch_output_first(link.switch_output_first),
    .switch_output_second(link.switch_output_second),
    .test_in(link.test_in));
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 pclk = ~pclk;
  task automatic check(input string w, input logic [31:0] e,
    input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, e, q);
  endtask : rd
  task automatic step(input int n, input logic [1:0] d, input int gap);
    repeat (n) begin
      {step_rev, step_fwd} <= d;
      @(posedge pclk);
      {step_rev, step_fwd} <= 2'b00;
      repeat (gap) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : step
  task automatic irq_is(input logic e);
    @(negedge pclk);
    check("irq", {31'h0, e}, {31'h0, irq});
    @(posedge pclk);
  endtask : irq_is
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, step_fwd, step_rev} = '0;
    {ref_mark_seen, ref_select_track, selectable_ref, signal_fault} = '0;
    {switch_track_first, switch_track_second} = '0;
    {raw_test_first, raw_test_second, paddr, pwdata, ref_phase} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", ADDR_CTRL, {30'h0, CTRL_RESET});
    rd("mask", ADDR_MASK, {28'h0, MASK_RESET});
    rd("preset", ADDR_PRESET, PRESET_RESET);
    rd("unmapped", 8'h18, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_POS, 32'h0000_00ff);
    rd("pos", ADDR_POS, POS_RESET);
    irq_is(1'b0);
    $display("reset test done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    foreach (rows[i]) begin
      {selectable_ref, signal_fault, switch_track_second,
        switch_track_first} <= rows[i].pin;
      step(rows[i].n, rows[i].d, 16);
      rd("pos", ADDR_POS, rows[i].pos);
      apb(1'b0, ADDR_LEVELS, 32'h0);
      check("levels", {29'h0, rows[i].lv}, {29'h0, q[4:2]});
      $display("row %0d done", i);
    end
    rd("status", ADDR_STATUS, 32'h4);
    irq_is(1'b0);
    apb(1'b1, ADDR_MASK, 32'hf);
    irq_is(1'b1);
    signal_fault <= 1'b0;
    step(1, 2'b00, 4);
    apb(1'b1, ADDR_STATUS, 32'hf);
    irq_is(1'b0);
    $display("interrupt test done");
    step(2, 2'b01, 2);
    rd("status", ADDR_STATUS, 32'h8);
    rd("pos", ADDR_POS, 32'h0000_0001);
    apb(1'b1, ADDR_STATUS, 32'hf);
    $display("spacing test done");
    ref_phase <= 8'h07;
    apb(1'b1, ADDR_PRESET, 32'h0000_0123);
    apb(1'b1, ADDR_CTRL, 32'h3);
    ref_mark_seen <= 1'b1;
    for (int k = 0; k < 44 && irq !== 1'b1; k++) step(1, 2'b01, 8);
    rd("pos", ADDR_POS, 32'h0000_0123);
    step(1, 2'b01, 8);
    apb(1'b1, ADDR_PRESET, 32'h0000_0456);
    apb(1'b1, ADDR_STATUS, 32'hf);
    step(1, 2'b10, 8);
    rd("status", ADDR_STATUS, 32'h1);
    rd("pos", ADDR_POS, 32'h0000_0456);
    selectable_ref <= 1'b1;
    apb(1'b1, ADDR_STATUS, 32'hf);
    step(1, 2'b01, 8);
    step(1, 2'b10, 8);
    rd("status", ADDR_STATUS, 32'h0);
    step(1, 2'b01, 8);
    ref_select_track <= 1'b1;
    step(1, 2'b10, 8);
    rd("status", ADDR_STATUS, 32'h1);
    $display("reference test done");
    apb(1'b1, ADDR_STATUS, 32'hf);
    raw_test_second <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h4);
    rd("ctrl", ADDR_CTRL, 32'h4);
    raw_test_first <= 1'b1;
    step(1, 2'b00, 8);
    apb(1'b0, ADDR_LEVELS, 32'h0);
    check("raw levels", 32'h3, {30'h0, q[1:0]});
    {raw_test_first, raw_test_second} <= 2'b00;
    step(1, 2'b00, 8);
    raw_test_second <= 1'b1;
    step(1, 2'b00, 8);
    rd("status", ADDR_STATUS, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h0);
    $display("test mode done");
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd("pos", ADDR_POS, POS_RESET);
    complete_run();
  end
endmodule : incremental_quadrature_encoder_output_tb
`default_nettype wire
